// ### logic/lsw_pkg.sv
package lsw_pkg;
  // =====================================
  // widths and channel groups
  localparam int LSW_NCH = 8;
  localparam int LSW_NSER = 6;
  localparam int LSW_CMD_W = 8;
  localparam int LSW_ONOL_LO_BIT = 6;
  localparam int LSW_ONOL_HI_BIT = 7;
  // =====================================
  // reset values
  localparam logic [7:0] LSW_CMD_RST = 8'h00;
  localparam logic [7:0] LSW_FAULT_RST = 8'h00;
  // =====================================
  // timing, ns at a 5 ns clock
  localparam int LSW_CLK_NS = 5;
  localparam int LSW_SC_SENSE_NS = 1000;
  localparam int LSW_FAULT_MASK_NS = 500;
  localparam int LSW_OL_SENSE_NS = 2000;
  localparam int LSW_RETRY_NS = 10000;
  // least times round up
  localparam int LSW_SC_SENSE_CYC = (LSW_SC_SENSE_NS + LSW_CLK_NS - 1) / LSW_CLK_NS;
  localparam int LSW_FAULT_MASK_CYC = (LSW_FAULT_MASK_NS + LSW_CLK_NS - 1) / LSW_CLK_NS;
  localparam int LSW_OL_SENSE_CYC = (LSW_OL_SENSE_NS + LSW_CLK_NS - 1) / LSW_CLK_NS;
  localparam int LSW_RETRY_CYC = (LSW_RETRY_NS + LSW_CLK_NS - 1) / LSW_CLK_NS;
  localparam int LSW_TMR_W = 12;
  typedef enum logic [1:0] {LSW_CH_OFF, LSW_CH_ON, LSW_CH_RETRY} lsw_ch_state_t;
endpackage

// ### logic/lsw_sync.sv
`timescale 1ns/1ps
// =====================================
// two flop synchroniser, vector wide
module lsw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### logic/lsw_chan.sv
`timescale 1ns/1ps
import lsw_pkg::*;
// =====================================
// one channel: short protection with retry, open load filter
module lsw_chan #(
  parameter int SC_CYC = LSW_SC_SENSE_CYC,
  parameter int MASK_CYC = LSW_FAULT_MASK_CYC,
  parameter int OL_CYC = LSW_OL_SENSE_CYC,
  parameter int RETRY_CYC = LSW_RETRY_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_on,
  input wire logic shutdown,
  input wire logic on_ol_en,
  input wire logic i_limit,
  input wire logic drain_low,
  output logic drive,
  output logic fault_pulse
);
  initial begin
    if (SC_CYC < 1 || MASK_CYC < 1 || OL_CYC < 1 || RETRY_CYC < 1 ||
        SC_CYC >= 4096 || MASK_CYC >= 4096 || OL_CYC >= 4096 || RETRY_CYC >= 4096)
      $error("lsw_chan: timing counts out of range");
  end
  lsw_ch_state_t st_r;
  logic [LSW_TMR_W-1:0] sc_cnt_r;
  logic [LSW_TMR_W-1:0] ol_cnt_r;
  logic [LSW_TMR_W-1:0] retry_cnt_r;
  logic was_on_r;
  logic want_on;
  logic sc_limit;
  logic sc_hit;
  logic ol_watch;
  logic ol_limit;
  assign want_on = cmd_on && !shutdown;
  // a fresh turn-on gets the long sense time; a short while already on uses the mask
  assign sc_limit = was_on_r ? 1'b0 : 1'b1;
  assign sc_hit = i_limit && (sc_limit ? (sc_cnt_r >= LSW_TMR_W'(SC_CYC - 1))
                                      : (sc_cnt_r >= LSW_TMR_W'(MASK_CYC - 1)));
  assign drive = (st_r == LSW_CH_ON);
  // =====================================
  // state
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= LSW_CH_OFF;
      sc_cnt_r <= '0;
      retry_cnt_r <= '0;
      was_on_r <= 1'b0;
    end else begin
      case (st_r)
        LSW_CH_OFF: begin
          sc_cnt_r <= '0;
          was_on_r <= 1'b0;
          if (want_on) st_r <= LSW_CH_ON;
        end
        LSW_CH_ON: begin
          if (!want_on) begin
            st_r <= LSW_CH_OFF;
          end else if (sc_hit) begin
            st_r <= LSW_CH_RETRY;
            retry_cnt_r <= '0;
            sc_cnt_r <= '0;
          end else if (i_limit) begin
            sc_cnt_r <= sc_cnt_r + 1'b1;
          end else begin
            sc_cnt_r <= '0;
            if (sc_cnt_r == '0) was_on_r <= 1'b1;
          end
        end
        LSW_CH_RETRY: begin
          // low duty cycle: off for the refresh time, then one more try
          if (!want_on) begin
            st_r <= LSW_CH_OFF;
          end else if (retry_cnt_r >= LSW_TMR_W'(RETRY_CYC - 1)) begin
            st_r <= LSW_CH_ON;
            was_on_r <= 1'b0;
          end else begin
            retry_cnt_r <= retry_cnt_r + 1'b1;
          end
        end
        default: st_r <= LSW_CH_OFF;
      endcase
    end
  end
  // =====================================
  // open load: while off, or while on when enabled
  assign ol_watch = drain_low && (!drive || on_ol_en);
  assign ol_limit = (ol_cnt_r >= LSW_TMR_W'(OL_CYC - 1));
  always_ff @(posedge clk) begin
    if (reset) begin
      ol_cnt_r <= '0;
    end else if (!ol_watch) begin
      ol_cnt_r <= '0;
    end else if (!ol_limit) begin
      ol_cnt_r <= ol_cnt_r + 1'b1;
    end
  end
  // level pulse each cycle while a filtered fault is present, so a cleared bit sets again
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_pulse <= 1'b0;
    end else begin
      fault_pulse <= (st_r == LSW_CH_ON && sc_hit) || (st_r == LSW_CH_RETRY) ||
                     (ol_watch && ol_limit);
    end
  end
endmodule

// ### logic/lsw_top.sv
`timescale 1ns/1ps
import lsw_pkg::*;
module lsw_top #(
  parameter int NCH = LSW_NCH,
  parameter int SC_CYC = LSW_SC_SENSE_CYC,
  parameter int MASK_CYC = LSW_FAULT_MASK_CYC,
  parameter int OL_CYC = LSW_OL_SENSE_CYC,
  parameter int RETRY_CYC = LSW_RETRY_CYC
) (
  input wire logic clk,
  input wire logic reset,
  // serial link, own clock domain
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // pins
  input wire logic mode,
  input wire logic [5:0] parallel_ctl_pin,
  input wire logic parallel_ctl_pin_6,
  input wire logic parallel_ctl_pin_7,
  input wire logic overvoltage,
  input wire logic sc_shutdown,
  input wire logic [NCH-1:0] current_limit,
  input wire logic [NCH-1:0] drain_below_ol,
  // outputs
  output logic [5:0] power_channel,
  output logic low_power_channel_6,
  output logic low_power_channel_7,
  output logic [NCH-1:0] fault_status
);
  initial begin
    if (NCH != LSW_NCH) $error("lsw_top: only eight channels supported");
  end
  // =====================================
  // link domain: shift register on sclk, reset by chip select high
  logic [LSW_CMD_W-1:0] rx_sh_r;
  logic [LSW_CMD_W-1:0] rx_first_r;
  logic [4:0] bit_cnt_r;
  logic rx_tog_r;
  logic [LSW_CMD_W-1:0] rx_word_r;
  logic [LSW_CMD_W-1:0] snap_w;
  logic [LSW_CMD_W-1:0] rx_sh_nxt;
  assign rx_sh_nxt = {rx_sh_r[LSW_CMD_W-2:0], sdi};
  // bit count and shift, cleared while deselected (async by the frame's own signal)
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= '0;
      rx_sh_r <= LSW_CMD_RST;
      rx_first_r <= LSW_CMD_RST;
    end else begin
      rx_sh_r <= rx_sh_nxt;
      if (bit_cnt_r != 5'h1F) bit_cnt_r <= bit_cnt_r + 5'h01;
      if (bit_cnt_r == 5'h07) rx_first_r <= rx_sh_nxt;
    end
  end
  // =====================================
  // snapshot: taken as chip select falls, held through the frame
  logic [LSW_CMD_W-1:0] fault_r;
  logic [LSW_CMD_W-1:0] snap_r;
  always_ff @(negedge cs_n) begin
    snap_r <= fault_r;
  end
  // serial out shifts on falling sclk; first bit is msb of snapshot
  logic [4:0] out_idx_r;
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_idx_r <= '0;
    end else if (bit_cnt_r != 5'h00 && out_idx_r != 5'h1F) begin
      out_idx_r <= out_idx_r + 5'h01;
    end
  end
  assign snap_w = snap_r;
  always_comb begin
    if (out_idx_r < 5'd8) begin
      sdo = snap_w[3'd7 - out_idx_r[2:0]];
    end else begin
      sdo = rx_first_r[3'd7 - out_idx_r[2:0]];
    end
  end
  assign sdo_oe = !cs_n && !mode;
  // latch the received command as chip select rises; word held stable after
  // the toggle must start known, or the system side never sees a new word
  always_ff @(posedge cs_n or posedge reset) begin
    if (reset) begin
      rx_word_r <= LSW_CMD_RST;
      rx_tog_r <= 1'b0;
    end else if (bit_cnt_r == 5'd8 || bit_cnt_r == 5'd16) begin
      rx_word_r <= rx_sh_r;
      rx_tog_r <= !rx_tog_r;
    end
  end
  // =====================================
  // system domain synchronisers
  logic [5:0] par_s;
  logic [1:0] lp_s;
  logic mode_s;
  logic ov_s;
  logic scs_s;
  logic cs_busy_s;
  logic rx_tog_s;
  logic [NCH-1:0] ilim_s;
  logic [NCH-1:0] olow_s;
  lsw_sync #(.W(6)) u_sync_par (.clk(clk), .reset(reset), .d(parallel_ctl_pin), .q(par_s));
  lsw_sync #(.W(2)) u_sync_lp (.clk(clk), .reset(reset),
    .d({parallel_ctl_pin_7, parallel_ctl_pin_6}), .q(lp_s));
  lsw_sync #(.W(5)) u_sync_ctl (.clk(clk), .reset(reset),
    .d({mode, overvoltage, sc_shutdown, !cs_n, rx_tog_r}), .q({mode_s, ov_s, scs_s, cs_busy_s, rx_tog_s}));
  lsw_sync #(.W(2*NCH)) u_sync_an (.clk(clk), .reset(reset),
    .d({current_limit, drain_below_ol}), .q({ilim_s, olow_s}));
  // =====================================
  // command register; word is stable long before the toggle is seen
  logic rx_tog_d_r;
  logic [LSW_CMD_W-1:0] cmd_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_tog_d_r <= 1'b0;
      cmd_r <= LSW_CMD_RST;
    end else begin
      rx_tog_d_r <= rx_tog_s;
      if (rx_tog_s != rx_tog_d_r && !ov_s && !scs_s) cmd_r <= rx_word_r;
    end
  end
  // =====================================
  // control selection
  logic [NCH-1:0] want;
  logic shutdown;
  assign shutdown = ov_s || scs_s;
  always_comb begin
    want = '0;
    if (mode_s) begin
      // each pair switches together, on when either pin of its pair is high
      want[0] = par_s[0] | par_s[1];
      want[1] = par_s[0] | par_s[1];
      want[2] = par_s[2] | par_s[3];
      want[3] = par_s[2] | par_s[3];
      want[4] = par_s[4] | par_s[5];
      want[5] = par_s[4] | par_s[5];
    end else begin
      want[5:0] = cmd_r[5:0] | par_s;
    end
    want[6] = lp_s[0];
    want[7] = lp_s[1];
  end
  // =====================================
  // channels
  logic [NCH-1:0] drive;
  logic [NCH-1:0] fpulse;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      lsw_chan #(.SC_CYC(SC_CYC), .MASK_CYC(MASK_CYC), .OL_CYC(OL_CYC), .RETRY_CYC(RETRY_CYC)) u_ch (
        .clk(clk),
        .reset(reset),
        .cmd_on(want[g]),
        .shutdown(shutdown),
        .on_ol_en((g < 6) ? (cmd_r[LSW_ONOL_LO_BIT] | cmd_r[LSW_ONOL_HI_BIT]) : 1'b0),
        .i_limit(ilim_s[g]),
        .drain_low(olow_s[g]),
        .drive(drive[g]),
        .fault_pulse(fpulse[g])
      );
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (reset) begin
      power_channel <= '0;
      low_power_channel_6 <= 1'b0;
      low_power_channel_7 <= 1'b0;
    end else begin
      power_channel <= drive[5:0];
      low_power_channel_6 <= drive[6];
      low_power_channel_7 <= drive[7];
    end
  end
  // =====================================
  // sticky fault register: frozen during the frame, cleared on its end, set wins
  logic cs_busy_d_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_busy_d_r <= 1'b0;
      fault_r <= LSW_FAULT_RST;
    end else begin
      cs_busy_d_r <= cs_busy_s;
      if (cs_busy_s) begin
        fault_r <= fault_r;
      end else if (cs_busy_d_r) begin
        fault_r <= fpulse;
      end else begin
        fault_r <= fault_r | fpulse;
      end
    end
  end
  assign fault_status = fault_r;
endmodule

// ### testbench/lsw_top_checker.sv
`timescale 1ns/1ps
// ========
// protection, mode and fault register checks
module lsw_top_checker #(
  parameter int SC_CYC = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic mode,
  input wire logic overvoltage,
  input wire logic sc_shutdown,
  input wire logic [5:0] parallel_ctl_pin,
  input wire logic [7:0] current_limit,
  input wire logic [7:0] drain_below_ol,
  input wire logic [5:0] power_channel,
  input wire logic low_power_channel_6,
  input wire logic low_power_channel_7,
  input wire logic [7:0] fault_status
);
  localparam int SCW = SC_CYC + 8;
  logic [3:0] since_low;
  logic [5:0] ol_cnt;
  wire off_all = ~|{power_channel, low_power_channel_6, low_power_channel_7};
  wire quiet = !overvoltage && !sc_shutdown && !current_limit;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // cs_n is asynchronous, so clears are allowed a few cycles after it rises
  always_ff @(posedge clk) begin
    since_low <= (reset || !cs_n) ? 4'h0 : since_low + 4'(since_low != 4'hf);
  end
  always_ff @(posedge clk) begin
    ol_cnt <= (reset || !cs_n || !drain_below_ol[7] || low_power_channel_7) ? 6'h00 : ol_cnt + 6'(ol_cnt != 6'h3f);
  end
  property p_mode_tri; mode [*4] |-> !sdo_oe; endproperty
  property p_idle_tri; cs_n [*4] |-> !sdo_oe; endproperty
  property p_sc_off; sc_shutdown [*5] |-> off_all; endproperty
  property p_ov_off; overvoltage [*5] |-> off_all; endproperty
  property p_pairs;
    (mode && quiet) [*6] |-> power_channel[0] == power_channel[1] && power_channel[2] == power_channel[3]
      && power_channel[4] == power_channel[5];
  endproperty
  property p_or; (!mode && quiet && $stable(parallel_ctl_pin)) [*6] |-> &(power_channel | ~parallel_ctl_pin); endproperty
  property p_sticky; |($past(fault_status) & ~fault_status) |-> since_low < 4'hc; endproperty
  property p_ol; ol_cnt == 6'h28 |-> fault_status[7]; endproperty
  property p_sc; (power_channel[0] && current_limit[0]) [*2] |-> ##[1:SCW] !power_channel[0]; endproperty
  a_mode_tri: assert property (p_mode_tri) else $error("serial out driven in mode");
  a_idle_tri: assert property (p_idle_tri) else $error("serial out driven while idle");
  a_sc_off: assert property (p_sc_off) else $error("channel on in shutdown");
  a_ov_off: assert property (p_ov_off) else $error("channel on in overvoltage");
  a_pairs: assert property (p_pairs) else $error("pair outputs differ");
  a_or: assert property (p_or) else $error("pin high but output off");
  a_sticky: assert property (p_sticky) else $error("fault bit cleared without read");
  a_ol: assert property (p_ol) else $error("open load not flagged");
  a_sc: assert property (p_sc) else $error("limited channel not turned off");
  c_frame: cover property (!cs_n ##1 cs_n);
  c_fault: cover property ($rose(fault_status[0]));
  c_mode: cover property (mode && !off_all);
endmodule
bind lsw_top lsw_top_checker #(.SC_CYC(SC_CYC)) chk_u (.clk, .reset, .cs_n, .sdo_oe, .mode, .overvoltage,
  .sc_shutdown, .parallel_ctl_pin, .current_limit, .drain_below_ol, .power_channel, .low_power_channel_6,
  .low_power_channel_7, .fault_status);

// ### testbench/lsw_spi_host.sv
`timescale 1ns/1ps
// ========
// serial master; sclk idles low, the line has a pull-up
module lsw_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // a tristated output could not feed a second device in a chain
  wire line = sdo_oe ? sdo : 1'b1;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #16;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #16 sclk = 1'b1;
      rx = {rx[14:0], line};
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    // released data line must not keep its last value
    sdi = ~sdi;
    #64;
  endtask
endmodule

// ### testbench/test_switch_mode_and_fault_logic.sv
`timescale 1ns/1ps
// ========
// main sequence
module test_switch_mode_and_fault_logic;
  logic clk, reset, sclk, cs_n, sdi, sdo, sdo_oe, mode, p6, p7, ov, scs, lp6, lp7;
  logic [5:0] pin, pwr;
  logic [7:0] cl, dol, fs, cmd;
  logic [15:0] rx;
  int bad_count = 0, samples_checked = 0, cyc = 0, n;
  integer seed = 32'hbb77_c4a5;
  lsw_top #(.SC_CYC(8), .MASK_CYC(4), .OL_CYC(8), .RETRY_CYC(40)) dut_u (.clk, .reset, .sclk, .cs_n, .sdi,
    .sdo, .sdo_oe, .mode, .parallel_ctl_pin(pin), .parallel_ctl_pin_6(p6), .parallel_ctl_pin_7(p7),
    .overvoltage(ov), .sc_shutdown(scs), .current_limit(cl), .drain_below_ol(dol), .power_channel(pwr),
    .low_power_channel_6(lp6), .low_power_channel_7(lp7), .fault_status(fs));
  lsw_spi_host host_u (.sclk, .cs_n, .sdi, .sdo, .sdo_oe);
  function automatic logic [15:0] exp_out(input logic [7:0] c, input logic [5:0] p);
    return 16'(c[5:0] | p);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic send(input int k, input logic [15:0] tx);
    host_u.xfer(k, tx, rx);
    w(12);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    {mode, pin, p6, p7, ov, scs, cl, dol} = '0;
    reset = 1'b1;
    w(5);
    reset = 1'b0;
    w(4);
    chk("outputs", 16'h0000, 16'(pwr));
    repeat (6) begin
      cmd = $random(seed);
      pin = $random(seed);
      send(16, {~cmd, cmd});
      chk("verify", {8'h00, ~cmd}, rx);
      chk("outputs", exp_out(cmd, pin), 16'(pwr));
    end
    $display("random frames done");
    mode = 1'b1;
    cmd = 8'h15;
    pin = 6'h05;
    send(8, {8'h00, cmd});
    chk("status", 16'h00ff, rx);
    chk("outputs", 16'h000f, 16'(pwr));
    mode = 1'b0;
    w(8);
    chk("outputs", exp_out(cmd, pin), 16'(pwr));
    send(8, {8'h00, cmd});
    chk("status", 16'h0000, rx);
    {p7, p6} = 2'b11;
    w(8);
    chk("low power", 16'h0003, 16'({lp7, lp6}));
    {p7, p6} = 2'b00;
    $display("mode test done");
    pin = 6'h00;
    send(8, 16'h0000);
    dol = 8'h01;
    w(2);
    dol = 8'h00;
    w(20);
    chk("fault", 16'h0000, 16'(fs));
    dol = 8'h80;
    w(50);
    dol = 8'h00;
    w(10);
    chk("fault", 16'h0080, 16'(fs));
    fork
      send(8, 16'h0000);
      begin
        w(30);
        dol = 8'h40;
      end
    join
    chk("status", 16'h0080, rx);
    chk("fault", 16'h0040, 16'(fs));
    dol = 8'h00;
    send(8, 16'h0001);
    $display("fault test done");
    // command held steady through the short so the duty cycle is not overridden
    cl = 8'h01;
    w(30);
    chk("outputs", 16'h0000, 16'(pwr));
    chk("fault", 16'h0001, 16'(fs));
    n = 0;
    repeat (100) begin
      w(1);
      n += int'(pwr[0]);
    end
    chk("retry", 16'h0001, 16'(n > 0 && n < 50));
    cl = 8'h00;
    w(60);
    chk("outputs", 16'h0001, 16'(pwr));
    chk("fault", 16'h0001, 16'(fs));
    $display("short test done");
    for (int k = 0; k < 2; k++) begin
      {ov, scs} = k ? 2'b01 : 2'b10;
      w(8);
      chk("outputs", 16'h0000, 16'(pwr));
      send(8, 16'h0002);
      {ov, scs} = 2'b00;
      w(8);
      chk("outputs", 16'h0001, 16'(pwr));
    end
    $display("shutdown test done");
    results();
  end
endmodule
